/* File: bench/tb_top.sv */
// Self-checking bench for the watchdog and reset-source block.
// Assumes the design's register port, reset pulses and UV_QUAL_CYC of 8.
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_on = 1'b0;
  logic tsub = 1'b0;
  logic keep;
  logic sub = 1'b0;
  logic rc = 1'b0;
  logic low = 1'b0;
  logic clr = 1'b0;
  logic halt = 1'b0;
  logic slp = 1'b0;
  logic pd = 1'b0;
  reset_ctl_pkg::reg_req_t req = '0;
  logic [7:0] rdata;
  logic full_reset;
  logic warm_reset;
  logic pc_sp_clear;
  logic port_preset;
  logic run;
  int v;
  int bad_count = 0;
  int cmp_count = 0;
  int fr_cnt = 0;
  int wr_cnt = 0;
  int cyc = 0;
  int n;
  row_t rows[9];
  initial begin
    forever #10 clk = ~clk;
  end
  watchdog_and_reset_control #(.UV_QUAL_CYC(8)) u_dut (.clk(clk), .rst_n(rst_n),
    .cfg_always_on(cfg_on), .cfg_tick_sub(tsub), .slow_sub_clock(sub),
    .internal_slow_rc(rc), .low_supply(low), .clr_instr(clr), .halt_instr(halt),
    .sleep_mode(slp), .powerdown_mode(pd), .bus(req), .rdata(rdata),
    .full_reset(full_reset), .warm_reset(warm_reset), .pc_sp_clear(pc_sp_clear),
    .port_preset(port_preset), .idle_sysclk_keep(keep), .watchdog_running(run));
  // Slow clocks, reset-pulse counters and the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 10 == 9) rc <= ~rc;
    if (cyc % 7 == 6) sub <= ~sub;
    if (full_reset === 1'b1) fr_cnt <= fr_cnt + 1;
    if (warm_reset === 1'b1) wr_cnt <= wr_cnt + 1;
    if (cyc == 15000) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end
  task report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
  endtask
  task rchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task wait_rst(input int lim, output int k);
    int s;
    s = fr_cnt + wr_cnt;
    k = 0;
    while (fr_cnt + wr_cnt == s && k < lim) begin
      @(posedge clk);
      #1 k++;
    end
  endtask
  task pulse(input logic is_halt);
    @(posedge clk);
    if (is_halt) halt <= 1'b1;
    else clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    halt <= 1'b0;
  endtask
  task idle(input int k);
    repeat (k) @(posedge clk);
  endtask
  initial begin
    rows = '{'{4'h2, 8'h33, 8'h33}, '{4'h2, 8'h99, 8'h99}, '{4'h2, 8'haa, 8'haa},
             '{4'h2, 8'h55, 8'h55}, '{4'h3, 8'hff, 8'h00}, '{4'h5, 8'ha5, 8'h00},
             '{4'h1, 8'hff, 8'h80}, '{4'h1, 8'h00, 8'h00}, '{4'h0, 8'haa, 8'haa}};
    idle(20);
    chk({6'h00, pc_sp_clear, port_preset}, 8'h03);
    rst_n <= 1'b1;
    idle(3);
    rchk(4'h0, 8'h53);
    rchk(4'h2, 8'h55);
    rchk(4'h1, 8'h00);
    rchk(4'h3, 8'h00);
    chk({7'h00, run}, 8'h01);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    chk({7'h00, run}, 8'h00);
    cfg_on <= 1'b1;
    wr(4'h0, 8'haa);
    idle(1);
    chk({7'h00, run}, 8'h01);
    cfg_on <= 1'b0;
    wr(4'h0, 8'haa);
    $display("test registers done");
    // Short dip, dip in power-down, then a qualified low supply
    wr(4'h2, 8'h99);
    low <= 1'b1;
    idle(5);
    low <= 1'b0;
    idle(20);
    pd <= 1'b1;
    low <= 1'b1;
    idle(40);
    low <= 1'b0;
    pd <= 1'b0;
    idle(5);
    chk(8'(fr_cnt), 8'h00);
    low <= 1'b1;
    wait_rst(60, n);
    low <= 1'b0;
    chk(8'(fr_cnt), 8'h01);
    idle(5);
    rchk(4'h1, 8'h04);
    rchk(4'h2, 8'h99);
    rchk(4'h3, 8'h00);
    wr(4'h1, 8'h00);
    rchk(4'h1, 8'h00);
    $display("test undervoltage done");
    // Undefined threshold and enable codes
    wr(4'h2, 8'h12);
    wait_rst(80, n);
    chk(8'(n >= 40 && n <= 64), 8'h01);
    idle(3);
    rchk(4'h2, 8'h55);
    rchk(4'h1, 8'h02);
    wr(4'h0, 8'h00);
    wait_rst(80, n);
    chk(8'(n >= 40 && n <= 64), 8'h01);
    idle(3);
    rchk(4'h1, 8'h03);
    rchk(4'h0, 8'h53);
    wr(4'h1, 8'h00);
    rchk(4'h1, 8'h00);
    $display("test bad codes done");
    // Periodic clearing holds off the overflow, then it is let run out
    wr(4'h0, 8'h50);
    n = fr_cnt;
    repeat (4) begin
      idle(800);
      pulse(1'b0);
    end
    chk(8'(fr_cnt - n), 8'h00);
    wait_rst(1200, n);
    chk(8'(n >= 1000 && n <= 1040), 8'h01);
    idle(3);
    rchk(4'h3, 8'h01);
    rchk(4'h0, 8'h53);
    $display("test overflow done");
    // Overflow while asleep only warm-resets
    wr(4'h1, 8'h80);
    #1 chk({7'h00, keep}, 8'h01);
    wr(4'h0, 8'h50);
    pulse(1'b1);
    slp <= 1'b1;
    n = fr_cnt;
    wait_rst(1200, v);
    slp <= 1'b0;
    chk(8'(wr_cnt), 8'h01);
    chk(8'(fr_cnt - n), 8'h00);
    idle(3);
    rchk(4'h3, 8'h03);
    rchk(4'h0, 8'h50);
    $display("test sleep overflow done");
    // Sub-clock ticks pace the period instead of clk/4
    tsub <= 1'b1;
    pulse(1'b0);
    wait_rst(4000, n);
    chk(8'(n >= 3570 && n <= 3600), 8'h01);
    $display("test sub clock done");
    report_and_stop();
  end
endmodule

/* File: core/reset_ctl_pkg.sv */
// Constants and carrier types for the watchdog and reset-source block.
// Assumes a single 50 MHz clock; registers are 8 bits wide on a plain port.
package reset_ctl_pkg;
  // Register map
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_WDOG = 4'h0;
  localparam logic [3:0] OFS_CAUSE = 4'h1;
  localparam logic [3:0] OFS_THR = 4'h2;
  localparam logic [3:0] OFS_STAT = 4'h3;
  // Reset values
  localparam logic [7:0] WDOG_RESET = 8'h53;
  localparam logic [7:0] THR_RESET = 8'h55;
  // Watchdog enable codes and field layout
  localparam logic [4:0] CODE_DISABLE = 5'h15;
  localparam logic [4:0] CODE_ENABLE = 5'h0a;
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 3;
  localparam int SEL_MSB = 2;
  // Threshold codes: 2.1 V, 2.55 V, 3.15 V, 3.8 V
  localparam logic [7:0] THR_2V10 = 8'h55;
  localparam logic [7:0] THR_2V55 = 8'h33;
  localparam logic [7:0] THR_3V15 = 8'h99;
  localparam logic [7:0] THR_3V80 = 8'haa;
  // Cause register bits
  localparam int BIT_SYSON = 7;
  localparam int BIT_UVF = 2;
  localparam int BIT_TCF = 1;
  localparam int BIT_WCF = 0;
  // Status register bits
  localparam int BIT_PDF = 1;
  localparam int BIT_EXP = 0;
  // Watchdog counter
  localparam int CNT_W = 16;
  localparam logic [15:0] PERIOD_MIN = 16'h0100;
  localparam logic [1:0] SYSDIV_LAST = 2'h3;
  localparam logic [1:0] CODE_EDGE_LAST = 2'h2;
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int UV_QUAL_NS = 100000;
  localparam int UV_QUAL_CYC = (UV_QUAL_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

/* File: core/watchdog_and_reset_control.sv */
// Watchdog timer, protected enable codes, undervoltage reset qualification
// and reset-cause flags. Assumes the CPU core pulses clr_instr and
// halt_instr for one clock and reacts to the reset pulses it receives.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps

// Summary of operation
// - Every reset except sleep-mode watchdog warm reset reloads watchdog control to 0x53.
// - Always-on option: both valid codes run the watchdog; others reset the chip.
// - Register option: 10101 stops, 01010 runs; any other code resets the chip.
// - Invalid enable code resets after two to three slow RC cycles, sets flag.
// - Enable-code reset flag set by hardware only, cleared only by writing zero.
// - Timeout period is 2^(8+select) watchdog ticks.
// - Overflow in normal running gives full reset and sets expiry flag.
// - Overflow in sleep or idle sets expiry flag, resets only PC and stack.
// - Counter cleared by invalid-code reset, clear instruction or halt instruction.
// - Power-on reset zeroes the PC and presets port data and direction to ones.
// - Undervoltage resets only after low supply lasts past qualifying time; sets flag.
// - Threshold register accepts four codes selecting 2.1, 2.55, 3.15, 3.8 V.
// - Other threshold codes reset after two to three RC cycles, flag, reload 0x55.
// - A genuine undervoltage reset leaves the threshold register unchanged.
// - Undervoltage reset is disabled in power-down mode.
// - Undervoltage flag set by hardware only, cleared only by software writing zero.
// - Threshold-code flag set by hardware on undefined code, cleared only by software.
// - Watchdog tick comes from slow sub clock or system clock divided by four.
// - Power-on clears expiry and power-down flags; sleep-mode watchdog reset sets both.
module watchdog_and_reset_control #(
  parameter int UV_QUAL_CYC = reset_ctl_pkg::UV_QUAL_CYC
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration options
  input wire logic cfg_always_on,
  input wire logic cfg_tick_sub,
  // Pins from outside the clock domain
  input wire logic slow_sub_clock,
  input wire logic internal_slow_rc,
  input wire logic low_supply,
  // Core status and instruction strobes
  input wire logic clr_instr,
  input wire logic halt_instr,
  input wire logic sleep_mode,
  input wire logic powerdown_mode,
  // Register port
  input wire reset_ctl_pkg::reg_req_t bus,
  output logic [7:0] rdata,
  // Reset, sleep clock-keep and watchdog status outputs
  output logic full_reset,
  output logic warm_reset,
  output logic pc_sp_clear,
  output logic port_preset,
  output logic idle_sysclk_keep,
  output logic watchdog_running
);
  localparam int UVW = $clog2(UV_QUAL_CYC + 2);
  localparam logic [UVW-1:0] UV_LAST = UVW'(UV_QUAL_CYC);

  typedef struct packed {
    logic [1:0] sub_s;
    logic [1:0] rc_s;
    logic [1:0] low_s;
    logic sub_prev;
    logic rc_prev;
    logic [1:0] div;
    logic [7:0] wdog;
    logic [7:0] thr;
    logic syson;
    logic uvf;
    logic tcf;
    logic wcf;
    logic expf;
    logic powerdown_flag;
    logic [15:0] cnt;
    logic [1:0] wedge;
    logic [1:0] tedge;
    logic [UVW-1:0] uvcnt;
    logic [7:0] rdata;
    logic full;
    logic warm;
    logic pcclr;
    logic ports;
  } state_t;

  localparam state_t RST_VAL = '{
    wdog: reset_ctl_pkg::WDOG_RESET,
    thr: reset_ctl_pkg::THR_RESET,
    pcclr: 1'b1,
    ports: 1'b1,
    default: '0
  };

  logic [1:0] rst_sync;
  logic srst_n;
  state_t s;
  state_t n;

  logic sub_tick;
  logic rc_tick;
  logic sys_tick;
  logic tick;
  logic low;
  logic [4:0] code;
  logic code_ok;
  logic run;
  logic thr_ok;
  logic [15:0] period_last;
  logic ovf;
  logic wfire;
  logic tfire;
  logic uvfire;
  logic any_full;
  logic wr_cause;
  logic wr_thr;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign srst_n = rst_sync[1];

  always_comb begin
    sub_tick = s.sub_s[1] & ~s.sub_prev;
    rc_tick = s.rc_s[1] & ~s.rc_prev;
    low = s.low_s[1];
    sys_tick = (s.div == reset_ctl_pkg::SYSDIV_LAST) & (~sleep_mode | s.syson);
    tick = cfg_tick_sub ? sub_tick : sys_tick;
    code = s.wdog[reset_ctl_pkg::CODE_MSB:reset_ctl_pkg::CODE_LSB];
    code_ok = (code == reset_ctl_pkg::CODE_ENABLE) | (code == reset_ctl_pkg::CODE_DISABLE);
    run = (code == reset_ctl_pkg::CODE_ENABLE)
        | (cfg_always_on & (code == reset_ctl_pkg::CODE_DISABLE));
    thr_ok = (s.thr == reset_ctl_pkg::THR_2V10) | (s.thr == reset_ctl_pkg::THR_2V55)
           | (s.thr == reset_ctl_pkg::THR_3V15) | (s.thr == reset_ctl_pkg::THR_3V80);
    period_last = (reset_ctl_pkg::PERIOD_MIN << s.wdog[reset_ctl_pkg::SEL_MSB:0])
                - 16'h0001;
    ovf = run & tick & (s.cnt == period_last);
    // Third RC edge after the bad code appears: 2 to 3 RC periods
    wfire = ~code_ok & rc_tick & (s.wedge == reset_ctl_pkg::CODE_EDGE_LAST);
    tfire = ~thr_ok & rc_tick & (s.tedge == reset_ctl_pkg::CODE_EDGE_LAST);
    uvfire = low & ~powerdown_mode & (s.uvcnt == UV_LAST - UVW'(1));
    any_full = wfire | tfire | uvfire | (ovf & ~sleep_mode);
    wr_cause = bus.wr & (bus.addr == reset_ctl_pkg::OFS_CAUSE);
    wr_thr = bus.wr & (bus.addr == reset_ctl_pkg::OFS_THR);

    n = s;
    n.sub_s = {s.sub_s[0], slow_sub_clock};
    n.rc_s = {s.rc_s[0], internal_slow_rc};
    n.low_s = {s.low_s[0], low_supply};
    n.sub_prev = s.sub_s[1];
    n.rc_prev = s.rc_s[1];
    n.div = s.div + 2'h1;

    // Software writes first; hardware events below override them
    if (bus.wr && bus.addr == reset_ctl_pkg::OFS_WDOG) begin
      n.wdog = bus.wdata;
    end
    if (wr_thr) begin
      n.thr = bus.wdata;
    end
    if (wr_cause) begin
      n.syson = bus.wdata[reset_ctl_pkg::BIT_SYSON];
      n.uvf = s.uvf & bus.wdata[reset_ctl_pkg::BIT_UVF];
      n.tcf = s.tcf & bus.wdata[reset_ctl_pkg::BIT_TCF];
      n.wcf = s.wcf & bus.wdata[reset_ctl_pkg::BIT_WCF];
    end

    // Delay counters for invalid codes, counting RC edges
    if (code_ok) begin
      n.wedge = 2'h0;
    end else if (rc_tick) begin
      n.wedge = s.wedge + 2'h1;
    end
    if (thr_ok) begin
      n.tedge = 2'h0;
    end else if (rc_tick) begin
      n.tedge = s.tedge + 2'h1;
    end

    // Undervoltage qualification; saturates so one dip fires once
    if (!low || powerdown_mode) begin
      n.uvcnt = '0;
    end else if (s.uvcnt != UV_LAST) begin
      n.uvcnt = s.uvcnt + UVW'(1);
    end

    // Watchdog counter
    if (clr_instr || halt_instr || any_full || ovf) begin
      n.cnt = '0;
    end else if (run && tick) begin
      n.cnt = s.cnt + 16'h0001;
    end

    // Flags from instructions
    if (halt_instr) begin
      n.powerdown_flag = 1'b1;
      n.expf = 1'b0;
    end else if (clr_instr) begin
      n.powerdown_flag = 1'b0;
    end

    if (ovf) begin
      n.expf = 1'b1;
    end
    if (ovf && sleep_mode) begin
      n.powerdown_flag = 1'b1;
    end

    if (any_full) begin
      n.wdog = reset_ctl_pkg::WDOG_RESET;
      n.syson = 1'b0;
      n.wedge = 2'h0;
      n.tedge = 2'h0;
    end
    if (tfire || (ovf && !sleep_mode)) begin
      n.thr = reset_ctl_pkg::THR_RESET;
    end else if (uvfire) begin
      n.thr = wr_thr ? bus.wdata : s.thr;
    end

    // Hardware sets win over software clears
    if (wfire) begin
      n.wcf = 1'b1;
    end
    if (tfire) begin
      n.tcf = 1'b1;
    end
    if (uvfire) begin
      n.uvf = 1'b1;
    end

    n.full = any_full;
    n.warm = ovf & sleep_mode;
    n.pcclr = any_full | (ovf & sleep_mode);
    n.ports = any_full;

    n.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        reset_ctl_pkg::OFS_WDOG: n.rdata = s.wdog;
        reset_ctl_pkg::OFS_THR: n.rdata = s.thr;
        reset_ctl_pkg::OFS_CAUSE: n.rdata = {s.syson, 4'h0, s.uvf, s.tcf, s.wcf};
        reset_ctl_pkg::OFS_STAT: n.rdata = {6'h00, s.powerdown_flag, s.expf};
        default: n.rdata = 8'h00;
      endcase
    end
  end

  // Power-on clears both status flags and presets PC and ports
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      s <= RST_VAL;
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign full_reset = s.full;
  assign warm_reset = s.warm;
  assign pc_sp_clear = s.pcclr;
  assign port_preset = s.ports;
  assign idle_sysclk_keep = s.syson;
  assign watchdog_running = run;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!srst_n);

  a_wdog_reload: assert property (any_full |=> s.wdog == reset_ctl_pkg::WDOG_RESET)
    else $error("watchdog control not reloaded on full reset");
  a_code_run: assert property (
    code == reset_ctl_pkg::CODE_DISABLE |-> run == cfg_always_on)
    else $error("disable code handled wrongly for option");
  a_stop_holds: assert property (
    !run && !clr_instr && !halt_instr |=> s.cnt == $past(s.cnt) || s.cnt == 16'h0000)
    else $error("stopped watchdog counter moved");
  a_code_delay: assert property (wfire |=> s.full && s.wcf && s.pcclr)
    else $error("invalid enable code reset missing");
  a_code_sticky: assert property (
    s.wcf && !(wr_cause && !bus.wdata[reset_ctl_pkg::BIT_WCF]) |=> s.wcf)
    else $error("enable code flag lost without software clear");
  a_wcf_hw: assert property (!s.wcf && !wfire |=> !s.wcf)
    else $error("enable code flag set without a code reset");
  a_period_wrap: assert property (
    run && tick && s.cnt == period_last |=> s.cnt == 16'h0000 && s.expf && (s.full || s.warm))
    else $error("overflow at period end not handled");
  a_ovf_full: assert property (ovf && !sleep_mode |=> s.full && s.expf && !s.warm)
    else $error("normal overflow did not give a full reset");
  a_warm_flags: assert property (
    ovf && sleep_mode |=> s.warm && !s.full && s.powerdown_flag && s.expf)
    else $error("sleep overflow flags or pulse wrong");
  a_warm_keeps: assert property (
    ovf && sleep_mode && !any_full && !bus.wr
    |=> s.wdog == $past(s.wdog) && s.thr == $past(s.thr))
    else $error("sleep overflow changed control registers");
  a_clear_instr: assert property (clr_instr || halt_instr |=> s.cnt == 16'h0000)
    else $error("watchdog counter not cleared");
  a_full_preset: assert property (any_full |=> s.ports && s.pcclr)
    else $error("full reset did not preset ports and PC");
  a_uv_fire: assert property (uvfire |=> s.full && s.uvf ##1 !s.full)
    else $error("undervoltage reset or flag missing");
  a_thr_write: assert property (
    wr_thr && !tfire && !ovf && bus.wdata == reset_ctl_pkg::THR_3V15
    |=> s.thr == reset_ctl_pkg::THR_3V15 && thr_ok)
    else $error("valid threshold code not accepted");
  a_thr_restore: assert property (tfire |=> s.thr == reset_ctl_pkg::THR_RESET && s.tcf)
    else $error("threshold register not restored");
  a_thr_keep: assert property (
    uvfire && !tfire && !ovf && !wr_thr |=> s.thr == $past(s.thr))
    else $error("undervoltage reset changed threshold");
  a_uv_off: assert property (powerdown_mode && !s.uvf |=> s.uvcnt == '0 && !s.uvf)
    else $error("undervoltage qualify ran in power-down");
  a_uvf_sticky: assert property (
    s.uvf && !(wr_cause && !bus.wdata[reset_ctl_pkg::BIT_UVF]) |=> s.uvf)
    else $error("undervoltage flag lost");
  a_uvf_hw: assert property (!s.uvf && !uvfire |=> !s.uvf)
    else $error("undervoltage flag set without a reset");
  a_tcf_sticky: assert property (
    s.tcf && !(wr_cause && !bus.wdata[reset_ctl_pkg::BIT_TCF]) |=> s.tcf)
    else $error("threshold code flag lost without software clear");
  a_tcf_hw: assert property (!s.tcf && !tfire |=> !s.tcf)
    else $error("threshold code flag set without a code reset");
  a_tick_div: assert property (
    !cfg_tick_sub && tick |=> (cfg_tick_sub || !tick)[*3])
    else $error("system clock tick not divided by four");
  a_uv_status: assert property (
    uvfire && !ovf && !halt_instr && !clr_instr
    |=> s.expf == $past(s.expf) && s.powerdown_flag == $past(s.powerdown_flag))
    else $error("undervoltage reset changed status flags");
  a_halt_flags: assert property (halt_instr && !ovf |=> s.powerdown_flag && !s.expf)
    else $error("halt did not set power-down flag");
  a_clr_pdf: assert property (clr_instr && !halt_instr && !ovf |=> !s.powerdown_flag)
    else $error("clear instruction left power-down flag set");
  a_rdata_idle: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");

  c_code_reset: cover property (wfire ##1 s.full);
  c_sleep_ovf: cover property (ovf && sleep_mode);
  c_normal_ovf: cover property (ovf && !sleep_mode);
  c_uv_reset: cover property (uvfire);
  c_thr_reset: cover property (tfire ##1 s.thr == reset_ctl_pkg::THR_RESET);
endmodule
